// file: rtl/sbtc_defs.svh
// sbtc_defs.svh - constants of the sixteen bit timer/counter
// assumes: included by bare name from rtl files; definitions only
`ifndef SBTC_DEFS_SVH
`define SBTC_DEFS_SVH

// ----------------------------------------
// control word bit positions
// ----------------------------------------
`define SBTC_CTL_SRC_BIT 1
`define SBTC_CTL_SYNC_BIT 2
`define SBTC_CTL_GATE_BIT 6
`define SBTC_CTL_PS_LO 4
`define SBTC_CTL_PS_HI 5
`define SBTC_CTL_ON_BIT 15

// ----------------------------------------
// reset values and prescale terminal counts
// ----------------------------------------
`define SBTC_CTL_RST 16'h0000
`define SBTC_PERIOD_RST 16'hFFFF
`define SBTC_COUNT_RST 16'h0000
`define SBTC_PS_MAX_1 8'h00
`define SBTC_PS_MAX_8 8'h07
`define SBTC_PS_MAX_64 8'h3F
`define SBTC_PS_MAX_256 8'hFF
`define SBTC_PS_ZERO 8'h00

`endif

// file: rtl/sbtc_pkg.sv
// sbtc_pkg.sv - types of the sixteen bit timer/counter
// assumes: compiled before every other rtl file
package sbtc_pkg;
   // operating modes decoded from the control word
   typedef enum logic [1:0] {
      SBTC_TIMER,
      SBTC_GATED,
      SBTC_SYNC_CNT,
      SBTC_ASYNC_CNT
   } sbtc_mode_t;
   // prescale ratio codes: 1, 8, 64, 256
   typedef enum logic [1:0] {
      SBTC_DIV1,
      SBTC_DIV8,
      SBTC_DIV64,
      SBTC_DIV256
   } sbtc_div_t;
endpackage

// file: rtl/sbtc_prescaler.sv
// sbtc_prescaler.sv - divides input edges by 1, 8, 64 or 256
// assumes: edge_in is a one-cycle pulse in the ref_clk_in domain
`timescale 1ns/1ps
`include "sbtc_defs.svh"
module sbtc_prescaler
   import sbtc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // input edges and ratio
   input wire logic edge_in,
   input wire sbtc_div_t div_in,
   // ticks out
   sbtc_tick_if.src tick_out
);
   // ----------------------------------------
   // divide chain
   // ----------------------------------------
   logic [7:0] ps_q; // edges seen since last tick
   logic [7:0] ps_d;
   logic tick_q; // registered tick
   logic tick_d;

   // terminal count for each ratio
   function automatic logic [7:0] ps_max(input sbtc_div_t d);
      unique case (d)
         SBTC_DIV1: ps_max = `SBTC_PS_MAX_1;
         SBTC_DIV8: ps_max = `SBTC_PS_MAX_8;
         SBTC_DIV64: ps_max = `SBTC_PS_MAX_64;
         SBTC_DIV256: ps_max = `SBTC_PS_MAX_256;
      endcase
   endfunction

   // next state: a tick every n-th edge
   always_comb begin
      ps_d = ps_q;
      tick_d = 1'b0;
      if (tick_out.clear) begin
         ps_d = `SBTC_PS_ZERO;
      end else if (edge_in) begin
         if (ps_q >= ps_max(div_in)) begin
            ps_d = `SBTC_PS_ZERO;
            tick_d = 1'b1;
         end else begin
            ps_d = ps_q + 8'h01;
         end
      end
   end

   // registers only
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ps_q <= `SBTC_PS_ZERO;
         tick_q <= 1'b0;
      end else begin
         ps_q <= ps_d;
         tick_q <= tick_d;
      end
   end

   assign tick_out.tick = tick_q;

   // a divide-by-one ratio turns every edge into a tick one cycle later
   div1_pass_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (div_in == SBTC_DIV1 && edge_in && !tick_out.clear) |=> tick_q)
      else $error("divide by one lost an edge");
endmodule

// file: rtl/sbtc_tick_if.sv
// sbtc_tick_if.sv - carries prescaled count ticks from the prescaler to the counter
// assumes: a single clock domain, ticks are one-cycle pulses
`timescale 1ns/1ps
interface sbtc_tick_if;
   logic tick; // one-cycle count advance
   logic clear; // restart the divide chain
   modport src (output tick, input clear);
   modport dst (input tick, output clear);
endinterface

// file: rtl/sbtc_timer.sv
// sbtc_timer.sv - sixteen bit timer/counter, top level
// assumes: ref_clk_in is the instruction cycle clock; control bits are plain ports;
// the counter runs on ref_clk_in, so the asynchronous counter mode is modelled by
// a free edge path that skips the resynchroniser stage
//
// Functional notes
// - sixteen bit free running counter
// - asynchronous counting from the external clock
// - synchronise after the prescaler, not before
// - timer modes count instruction cycle clock
// - counter modes count external count clock
// - source select at control bit one
// - sync select at control bit two
// - gate enable at control bit six
// - mode decode from source, gate, sync
// - prescale by 1, 8, 64, 256
`timescale 1ns/1ps
`include "sbtc_defs.svh"
module sbtc_timer
   import sbtc_pkg::*;
#(
   parameter int CNT_W = 16 // counter width
)
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // control word and period
   input wire logic [15:0] timer_control_reg_in,
   input wire logic [CNT_W-1:0] period_in,
   // external pins
   input wire logic ext_count_clock_in,
   input wire logic gate_in,
   // software event flag handling
   input wire logic event_clear_in,
   // status
   output logic [CNT_W-1:0] count_out,
   output logic event_flag_out,
   output sbtc_mode_t mode_out
);
   // every check of this block runs on the rising clock and sleeps during reset
   default clocking chk_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   // ----------------------------------------
   // control word fields
   // ----------------------------------------
   logic clock_source_select; // 1: external count clock
   logic ext_clock_sync_select; // 1: synchronised counter
   logic gate_accumulate_enable; // gated timer when source is internal
   logic timer_on; // count enable
   sbtc_div_t div_sel; // prescale ratio
   sbtc_mode_t mode; // decoded mode

   assign clock_source_select = timer_control_reg_in[`SBTC_CTL_SRC_BIT];
   assign ext_clock_sync_select = timer_control_reg_in[`SBTC_CTL_SYNC_BIT];
   assign gate_accumulate_enable = timer_control_reg_in[`SBTC_CTL_GATE_BIT];
   assign timer_on = timer_control_reg_in[`SBTC_CTL_ON_BIT];
   assign div_sel = sbtc_div_t'(timer_control_reg_in[`SBTC_CTL_PS_HI:`SBTC_CTL_PS_LO]);

   // mode decode: the gate bit is ignored once the source is external
   function automatic sbtc_mode_t decode_mode(input logic src, input logic gt,
                                              input logic sy);
      if (!src) begin
         decode_mode = gt ? SBTC_GATED : SBTC_TIMER;
      end else begin
         decode_mode = sy ? SBTC_SYNC_CNT : SBTC_ASYNC_CNT;
      end
   endfunction

   assign mode = decode_mode(clock_source_select, gate_accumulate_enable,
                             ext_clock_sync_select);

   // ----------------------------------------
   // external pin edge detection
   // ----------------------------------------
   logic ext_prev_q; // last sample of the count pin
   logic ext_prev_d;
   logic ext_rise; // rising edge of the count pin

   // pins are taken as synchronous, so one sample gives the edge
   always_comb begin
      ext_prev_d = ext_count_clock_in;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_prev_d;
      end
   end

   assign ext_rise = ext_count_clock_in & ~ext_prev_q;

   // ----------------------------------------
   // prescaler input selection
   // ----------------------------------------
   logic ps_edge; // edge fed to the prescaler

   // internal modes use every instruction cycle; gated mode only while gate high
   always_comb begin
      ps_edge = 1'b0;
      if (timer_on) begin
         unique case (mode)
            SBTC_TIMER: ps_edge = 1'b1;
            SBTC_GATED: ps_edge = gate_in;
            SBTC_SYNC_CNT: ps_edge = ext_rise;
            SBTC_ASYNC_CNT: ps_edge = ext_rise;
         endcase
      end
   end

   sbtc_tick_if tick_bus ();

   sbtc_prescaler u_prescaler (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .edge_in(ps_edge),
      .div_in(div_sel),
      .tick_out(tick_bus)
   );

   // ----------------------------------------
   // post-prescaler synchroniser
   // ----------------------------------------
   // the sync stage sits after the divider so slow pins see only one delay
   logic sync_tick_q; // tick delayed one instruction cycle
   logic sync_tick_d;
   logic count_tick; // tick accepted by the counter

   always_comb begin
      sync_tick_d = tick_bus.tick;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync_tick_q <= 1'b0;
      end else begin
         sync_tick_q <= sync_tick_d;
      end
   end

   // the asynchronous path bypasses the synchroniser stage
   assign count_tick = (mode == SBTC_SYNC_CNT) ? sync_tick_q : tick_bus.tick;
   assign tick_bus.clear = ~timer_on;

   // ----------------------------------------
   // counter, period match and event flag
   // ----------------------------------------
   logic [CNT_W-1:0] count_q; // counter value
   logic [CNT_W-1:0] count_d;
   logic event_q; // sticky event flag
   logic event_d;
   sbtc_mode_t mode_q; // registered mode for status
   logic match; // counter at period on a tick

   assign match = count_tick && (count_q == period_in);

   // a match wins over a simultaneous clear so no event is lost
   always_comb begin
      count_d = count_q;
      event_d = event_q;
      if (count_tick) begin
         if (match) begin
            count_d = '0;
         end else begin
            count_d = count_q + 1'b1;
         end
      end
      if (event_clear_in) begin
         event_d = 1'b0;
      end
      if (match) begin
         event_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count_q <= CNT_W'(`SBTC_COUNT_RST);
         event_q <= 1'b0;
         mode_q <= SBTC_TIMER;
      end else begin
         count_q <= count_d;
         event_q <= event_d;
         mode_q <= mode;
      end
   end

   assign count_out = count_q;
   assign event_flag_out = event_q;
   assign mode_out = mode_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // clock comes from the default clocking, reset from the default disable iff, at the top of the module
   period_wrap_a: assert property (
      match |=> (count_q == '0) && event_q)
      else $error("period match did not wrap and flag");

   count_step_a: assert property (
      (count_tick && !match) |=> count_q == $past(count_q) + 1'b1)
      else $error("counter did not advance on a tick");

   hold_idle_a: assert property (
      !count_tick |=> $stable(count_q))
      else $error("counter moved without a tick");

   gate_low_a: assert property (
      (mode == SBTC_GATED && !gate_in) |-> !ps_edge)
      else $error("gated timer counted with gate low");

   timer_src_a: assert property (
      (mode == SBTC_TIMER && timer_on) |-> ps_edge)
      else $error("timer mode missed an instruction cycle");

   ext_src_a: assert property (
      (clock_source_select && !ext_rise) |-> !ps_edge)
      else $error("counter mode counted without a pin edge");

   sync_delay_a: assert property (
      (mode == SBTC_SYNC_CNT && $past(mode) == SBTC_SYNC_CNT)
      |-> count_tick == $past(tick_bus.tick))
      else $error("sync counter not delayed after prescaler");

   async_direct_a: assert property (
      mode == SBTC_ASYNC_CNT |-> count_tick == tick_bus.tick)
      else $error("async counter passed through synchroniser");

   mode_decode_a: assert property (
      timer_control_reg_in[`SBTC_CTL_SRC_BIT] |-> mode inside {SBTC_SYNC_CNT, SBTC_ASYNC_CNT})
      else $error("gate bit affected an external mode");
endmodule

// file: testbench/sbtc_ext_src.sv
// sbtc_ext_src.sv - behavioural external count clock source
// assumes: shares ref_clk_in with the timer; the pin idles low between bursts
`timescale 1ns/1ps
module sbtc_ext_src (
   // clock
   input wire logic ref_clk_in,
   // burst request
   input wire logic start_in,
   input wire logic [15:0] pulses_in,
   input wire logic [7:0] half_in,
   // pin and status
   output logic ext_clk_out,
   output logic busy_out
);
   int left_q = 0; // falling edges still owed
   int ph_q = 0; // cycles spent in the current level
   logic pin_q = 1'b0; // level on the count pin, low while idle
   assign ext_clk_out = pin_q;
   assign busy_out = (left_q != 0) || pin_q;
   // ----------------------------------------
   // pin generator
   // ----------------------------------------
   // moves on the falling edge so the timer always samples a settled level
   always @(negedge ref_clk_in) begin
      if (start_in && !busy_out) begin
         pin_q <= 1'b1;
         left_q <= int'(pulses_in);
         ph_q <= 1;
      end else if (busy_out) begin
         if (ph_q < int'(half_in)) begin
            ph_q <= ph_q + 1;
         end else begin
            ph_q <= 1;
            // each high phase is followed by a low one, one edge per pulse
            if (pin_q) begin
               pin_q <= 1'b0;
               left_q <= left_q - 1;
            end else begin
               pin_q <= 1'b1;
            end
         end
      end
   end
endmodule

// file: testbench/tb_sixteen_bit_timer_counter.sv
// tb_sixteen_bit_timer_counter.sv - self-checking bench of the timer/counter
// assumes: sbtc_pkg and the rtl files are compiled first
`timescale 1ns/1ps
module tb_sixteen_bit_timer_counter;
   import sbtc_pkg::*;
   localparam logic [15:0] ON = 16'h8000, SRC = 16'h0002, SYN = 16'h0004, GT = 16'h0040;
   localparam logic [15:0] D8 = 16'h0010, D64 = 16'h0020, D256 = 16'h0030;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [15:0] ctl = 16'h0000; // control word
   logic [15:0] period = 16'hFFFF;
   logic gate = 1'b0;
   logic clr = 1'b0;
   logic start = 1'b0; // burst request to the source model
   logic [15:0] pulses = 16'h0001;
   logic [7:0] half = 8'h01;
   logic ext_clk, busy, flag;
   logic [15:0] count;
   sbtc_mode_t mode;
   int n_fail = 0;
   int n_tests = 0;
   always #25 ref_clk_in = ~ref_clk_in;
   sbtc_timer #(.CNT_W(16)) i_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .timer_control_reg_in(ctl), .period_in(period), .ext_count_clock_in(ext_clk),
      .gate_in(gate), .event_clear_in(clr), .count_out(count), .event_flag_out(flag),
      .mode_out(mode));
   sbtc_ext_src i_src (.ref_clk_in(ref_clk_in), .start_in(start), .pulses_in(pulses),
      .half_in(half), .ext_clk_out(ext_clk), .busy_out(busy));
   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("tests=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   // ticks over k cycles once running; k is a whole number of divide periods
   task automatic rate(input logic [15:0] v, input logic g, input int k, input int exp);
      logic [15:0] c0;
      @(negedge ref_clk_in) begin ctl <= v; gate <= g; end
      cyc(6);
      c0 = count;
      cyc(k);
      check(count - c0, 16'(exp));
   endtask
   // one burst of p external pulses, prescaler cleared first by dropping on
   task automatic burst(input logic [15:0] v, input logic [15:0] p, input logic [7:0] h,
         input int exp);
      logic [15:0] c0;
      int i;
      @(negedge ref_clk_in) begin ctl <= 16'h0000; gate <= 1'b1; end
      @(negedge ref_clk_in) ctl <= v;
      cyc(4);
      c0 = count;
      @(negedge ref_clk_in) begin start <= 1'b1; pulses <= p; half <= h; end
      @(negedge ref_clk_in) start <= 1'b0;
      cyc(1);
      for (i = 0; i < 3000 && busy; i++) @(negedge ref_clk_in);
      if (busy) begin
         n_fail++;
         stop_test();
      end
      cyc(6);
      check(count - c0, 16'(exp));
   endtask
   // single edge: count moves d+1 falling edges after the pin rises
   task automatic lat(input logic [15:0] v, input int d);
      logic [15:0] c0;
      @(negedge ref_clk_in) ctl <= 16'h0000;
      @(negedge ref_clk_in) ctl <= v;
      cyc(4);
      c0 = count;
      @(negedge ref_clk_in) begin start <= 1'b1; pulses <= 16'h0001; half <= 8'h02; end
      @(negedge ref_clk_in) start <= 1'b0;
      cyc(d);
      check(count, c0);
      cyc(1);
      check(count, c0 + 16'h0001);
      cyc(6);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_decode();
      logic [15:0] v;
      sbtc_mode_t e;
      for (int i = 0; i < 8; i++) begin
         v = (i[0] ? SRC : 16'h0000) | (i[1] ? SYN : 16'h0000) | (i[2] ? GT : 16'h0000);
         e = !i[0] ? (i[2] ? SBTC_GATED : SBTC_TIMER) : (i[1] ? SBTC_SYNC_CNT : SBTC_ASYNC_CNT);
         @(negedge ref_clk_in) ctl <= v;
         cyc(2);
         check(16'(mode), 16'(e));
      end
      $display("test decode done");
   endtask
   task automatic t_period();
      logic [15:0] prev;
      int i;
      // the counter only returns to zero by reset, match or overflow past FFFF, so reset it in mid-run
      @(negedge ref_clk_in) begin resetn_in <= 1'b0; period <= 16'h0005; ctl <= 16'h0000; end
      cyc(2);
      check(count, 16'h0000);
      @(negedge ref_clk_in) resetn_in <= 1'b1;
      @(negedge ref_clk_in) ctl <= ON;
      check(16'(flag), 16'h0000);
      prev = count;
      for (i = 0; i < 80 && !flag; i++) begin
         prev = count;
         @(negedge ref_clk_in);
      end
      if (!flag) begin
         n_fail++;
         stop_test();
      end
      check(count, 16'h0000);
      check(prev, 16'h0005);
      @(negedge ref_clk_in) clr <= 1'b1;
      @(negedge ref_clk_in) clr <= 1'b0;
      check(16'(flag), 16'h0000);
      for (i = 0; i < 20 && !flag; i++) @(negedge ref_clk_in);
      if (!flag) begin
         n_fail++;
         stop_test();
      end
      check(16'(i), 16'h0004);
      // a clear held across the next match must lose to it
      @(negedge ref_clk_in) clr <= 1'b1;
      cyc(5);
      check(16'(flag), 16'h0001);
      cyc(1);
      check(16'(flag), 16'h0000);
      @(negedge ref_clk_in) begin clr <= 1'b0; period <= 16'hFFFF; ctl <= 16'h0000; end
      $display("test period done");
   endtask
   // internal clock rates, prescale ratios and the gate
   task automatic t_rates();
      rate(ON, 1'b0, 40, 40);
      rate(ON | SYN, 1'b0, 24, 24);
      rate(ON | D8, 1'b0, 64, 8);
      rate(ON | D64, 1'b0, 128, 2);
      rate(ON | D256, 1'b0, 512, 2);
      rate(16'h0000, 1'b0, 20, 0);
      rate(ON | GT, 1'b1, 30, 30);
      rate(ON | GT, 1'b0, 30, 0);
      rate(ON | SRC | SYN | GT, 1'b1, 30, 0);
      $display("test timer rates done");
   endtask
   // external pulse bursts in both counter modes
   task automatic t_bursts();
      burst(ON | SRC | SYN, 16'h0005, 8'h01, 5);
      burst(ON | SRC, 16'h0010, 8'h02, 16);
      burst(ON | SRC | SYN | D8, 16'h0007, 8'h01, 0);
      burst(ON | SRC | SYN | D64, 16'h0040, 8'h01, 1);
      burst(ON | SRC | D256, 16'h0100, 8'h01, 1);
      $display("test counter bursts done");
   endtask
   // pin to count latency, one stage longer when synchronised
   task automatic t_latency();
      lat(ON | SRC | SYN, 2);
      lat(ON | SRC, 1);
      $display("test latency done");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      cyc(3);
      check(count, 16'h0000);
      check({15'h0000, flag}, 16'h0000);
      check(16'(mode), 16'h0000);
      cyc(2);
      resetn_in <= 1'b1;
      t_decode();
      t_rates();
      t_bursts();
      t_latency();
      t_period();
      stop_test();
   end
endmodule
